// ### design/hcmc_map.vh
// Constants of the hub configuration-mode control block.
`ifndef HCMC_MAP_VH
`define HCMC_MAP_VH
`define HCMC_STATUS_CMD_OFFSET 8'hf8
`define HCMC_STATUS_CMD_RESET 8'h00
`define HCMC_BIT_CFG_ACTIVE 0
`define HCMC_BIT_SOFT_RESET 1
`define HCMC_RSVD_MASK 8'hfc
`define HCMC_SOFT_RESET_CYCLES 4'h4
`endif

// ### design/hcmc_strap_sync.v
// Two-flop synchroniser and release-time capture for the strap pins.
`timescale 1ns/1ps
`default_nettype none
module hcmc_strap_sync #(
	parameter WIDTH = 8
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire [WIDTH-1:0] pins_in,
	output reg [WIDTH-1:0] straps_out,
	output reg valid_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;
	reg [1:0] cnt_q;
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
			cnt_q <= 2'h0;
			straps_out <= {WIDTH{1'b0}};
			valid_out <= 1'b0;
		end else begin
			meta_q <= pins_in;
			sync_q <= meta_q;
			// Straps are latched once, after the synchroniser has filled.
			if (cnt_q != 2'h3) begin
				cnt_q <= cnt_q + 2'h1;
			end
			if (cnt_q == 2'h2) begin
				straps_out <= sync_q;
				valid_out <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### design/hcmc_top.v
// Configuration-mode status/command register and strap decoding of the hub.
`timescale 1ns/1ps
`default_nettype none
`include "hcmc_map.vh"
// How it works
// - Reserved bits 7:2 always read zero.
// - Soft reset reloads all configuration registers.
// - Soft reset settable only in SMBus mode.
// - Soft reset leaves configuration-active set.
// - Write one sets; hardware clears; zero ignored.
// - Entering I2C or SMBus mode sets flag.
// - Leaving I2C mode clears the flag.
// - Write one clears flag; zero ignored.
// - Floating mode strap pulled high selects I2C.
// - Polarity strap high gives active-high enables.
// - Both power straps low gives per-port power.
// - Charge strap high enables port charging.
module hcmc_top #(
	parameter PORTS = 4
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire serial_mode_select_n_in,
	input wire power_enable_polarity_in,
	input wire ganged_power_in,
	input wire full_power_management_n_in,
	input wire [PORTS-1:0] charge_enable_in,
	input wire i2c_mode_active_in,
	input wire [PORTS-1:0] port_power_request_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	output reg [7:0] reg_rdata_out,
	output wire smbus_mode_out,
	output wire config_regs_reload_out,
	output wire upstream_connect_allow_out,
	output wire individual_power_out,
	output reg [PORTS-1:0] port_power_enable_out,
	output wire [PORTS-1:0] port_charge_enable_out
);
	localparam SW = PORTS + 4;
	// Boot waits for the straps, run serves the host, soft reset counts down.
	localparam ST_BOOT = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_SRST = 2'h2;
	wire [SW-1:0] straps;
	wire straps_valid;
	wire mode_strap_n;
	wire polarity_strap;
	wire ganged_strap;
	wire full_pm_strap_n;
	wire [PORTS-1:0] charge_straps;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg cfg_active_q;
	reg cfg_active_d;
	reg soft_reset_q;
	reg soft_reset_d;
	reg [3:0] srst_cnt_q;
	reg [3:0] srst_cnt_d;
	reg [7:0] rdata_d;
	reg i2c_meta_q;
	reg i2c_sync_q;
	reg i2c_prev_q;
	wire i2c_enter;
	wire i2c_exit;
	wire hit;
	wire wr_hit;
	wire rd_hit;
	wire run_state;
	wire srst_last;
	wire cfg_clear_req;
	wire srst_req;
	// Straps are sampled once after reset; later pin changes are ignored.
	hcmc_strap_sync #(
		.WIDTH(SW)
	) hcmc_strap_sync_inst (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.pins_in({charge_enable_in, full_power_management_n_in, ganged_power_in,
			power_enable_polarity_in, serial_mode_select_n_in}),
		.straps_out(straps),
		.valid_out(straps_valid)
	);
	// Field split of the latched straps, lowest pin first.
	assign mode_strap_n = straps[0];
	assign polarity_strap = straps[1];
	assign ganged_strap = straps[2];
	assign full_pm_strap_n = straps[3];
	assign charge_straps = straps[SW-1:4];
	assign smbus_mode_out = straps_valid & ~mode_strap_n;
	assign individual_power_out = ~ganged_strap & ~full_pm_strap_n;
	assign port_charge_enable_out = straps_valid ? charge_straps : {PORTS{1'b0}};
	assign upstream_connect_allow_out = straps_valid & ~cfg_active_q;
	assign config_regs_reload_out = soft_reset_q;
	assign hit = (reg_addr_in == `HCMC_STATUS_CMD_OFFSET);
	assign wr_hit = reg_wr_in & hit;
	assign rd_hit = reg_rd_in & hit;
	assign run_state = (state_q == ST_RUN);
	assign srst_last = (srst_cnt_q == 4'h1);
	// Writes outside the run state are dropped: the mode is unknown or a reload is busy.
	assign cfg_clear_req = run_state & wr_hit & reg_wdata_in[`HCMC_BIT_CFG_ACTIVE];
	assign srst_req = run_state & wr_hit & reg_wdata_in[`HCMC_BIT_SOFT_RESET] & smbus_mode_out;
	// Ganged mode drives every enable from port 0's request.
	// Enables stay low until the straps settle, since the polarity is unknown before.
	genvar g;
	generate
		for (g = 0; g < PORTS; g = g + 1) begin : g_pwr
			wire req_sel;
			wire level;
			assign req_sel = individual_power_out ? port_power_request_in[g]
				: port_power_request_in[0];
			assign level = req_sel ^ ~polarity_strap;
			always @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					port_power_enable_out[g] <= 1'b0;
				end else if (!straps_valid) begin
					port_power_enable_out[g] <= 1'b0;
				end else begin
					port_power_enable_out[g] <= level;
				end
			end
		end
	endgenerate
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			i2c_meta_q <= 1'b0;
			i2c_sync_q <= 1'b0;
			i2c_prev_q <= 1'b0;
		end else begin
			i2c_meta_q <= i2c_mode_active_in;
			i2c_sync_q <= i2c_meta_q;
			i2c_prev_q <= i2c_sync_q;
		end
	end
	// Edges count only in I2C mode; the SMBus host owns the flag there.
	assign i2c_enter = ~smbus_mode_out & i2c_sync_q & ~i2c_prev_q;
	assign i2c_exit = ~smbus_mode_out & ~i2c_sync_q & i2c_prev_q;
	// Flag next value; any set wins over a concurrent clear.
	always @* begin
		cfg_active_d = cfg_active_q;
		if (state_q == ST_BOOT) begin
			if (straps_valid & (~mode_strap_n | i2c_sync_q)) begin
				cfg_active_d = 1'b1;
			end
		end else if ((state_q == ST_SRST) | srst_req) begin
			cfg_active_d = 1'b1;
		end else if (i2c_enter) begin
			cfg_active_d = 1'b1;
		end else if (i2c_exit) begin
			cfg_active_d = 1'b0;
		end else if (cfg_clear_req) begin
			cfg_active_d = 1'b0;
		end
	end
	// The reload pulse has a fixed length; other register files must finish within it.
	always @* begin
		state_d = state_q;
		soft_reset_d = soft_reset_q;
		srst_cnt_d = srst_cnt_q;
		case (state_q)
			ST_BOOT: begin
				if (straps_valid) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (srst_req) begin
					soft_reset_d = 1'b1;
					srst_cnt_d = `HCMC_SOFT_RESET_CYCLES;
					state_d = ST_SRST;
				end
			end
			ST_SRST: begin
				if (srst_last) begin
					soft_reset_d = 1'b0;
					state_d = ST_RUN;
				end
				srst_cnt_d = srst_cnt_q - 4'h1;
			end
			default: begin
				state_d = ST_BOOT;
			end
		endcase
	end
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= ST_BOOT;
			cfg_active_q <= 1'b0;
			soft_reset_q <= 1'b0;
			srst_cnt_q <= 4'h0;
		end else begin
			state_q <= state_d;
			cfg_active_q <= cfg_active_d;
			soft_reset_q <= soft_reset_d;
			srst_cnt_q <= srst_cnt_d;
		end
	end
	// Reserved bits are never stored, so writes to them vanish.
	always @* begin
		rdata_d = 8'h00;
		if (rd_hit) begin
			rdata_d[`HCMC_BIT_CFG_ACTIVE] = cfg_active_q;
			rdata_d[`HCMC_BIT_SOFT_RESET] = soft_reset_q;
		end
	end
	// Read data stands for one cycle per read cycle and is zero otherwise.
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= `HCMC_STATUS_CMD_RESET;
		end else begin
			reg_rdata_out <= rdata_d;
		end
	end
endmodule
`default_nettype wire

// ### verification/hcmc_host.sv
// Register host model issuing single-byte reads and writes.
`timescale 1ns/1ps
`default_nettype none
module hcmc_host (
	input wire core_clk_in,
	input wire [7:0] rdata_in,
	output logic wr_out = 1'b0,
	output logic rd_out = 1'b0,
	output logic [7:0] addr_out = 8'h00,
	output logic [7:0] wdata_out = 8'h00
);
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge core_clk_in);
		{wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
		@(negedge core_clk_in);
		q = rdata_in;
		// Idle lines show the inverse so stale data never looks fresh.
		{wr_out, rd_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// ### verification/hcmc_monitor.sv
// Port assertions of the configuration-mode control block.
`timescale 1ns/1ps
`default_nettype none
module hcmc_monitor (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire i2c_mode_active_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire [7:0] reg_rdata_out,
	input wire smbus_mode_out,
	input wire config_regs_reload_out,
	input wire upstream_connect_allow_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire hit = reg_wr_in && reg_addr_in == 8'hf8 && !config_regs_reload_out;
	sequence s_hold; config_regs_reload_out [*4] ##1 !config_regs_reload_out; endsequence
	a_rsvd_zero: assert property (reg_rd_in |=> !reg_rdata_out[7:2])
		else $error("rsvd");
	a_rdata_idle: assert property (!reg_rd_in |=> !reg_rdata_out)
		else $error("rdata");
	a_reload_len: assert property ($rose(config_regs_reload_out) |-> s_hold)
		else $error("len");
	a_reload_mode: assert property ($rose(config_regs_reload_out) |-> smbus_mode_out)
		else $error("mode");
	a_reload_blocks: assert property (config_regs_reload_out |-> !upstream_connect_allow_out)
		else $error("up");
	a_one_sets: assert property (hit && reg_wdata_in[1] && smbus_mode_out |=> config_regs_reload_out)
		else $error("set");
	a_zero_keeps: assert property (hit && !reg_wdata_in[1] |=> !config_regs_reload_out)
		else $error("zero");
	a_i2c_blocks: assert property (!smbus_mode_out && $rose(i2c_mode_active_in)
		|-> ##3 !upstream_connect_allow_out)
		else $error("i2c");
endmodule
bind hcmc_top hcmc_monitor hcmc_monitor_inst (.*);
`default_nettype wire

// ### verification/hub_config_mode_control_bench.sv
// Self-checking bench of the configuration-mode control block.
`timescale 1ns/1ps
`default_nettype none
module hub_config_mode_control_bench;
	logic core_clk_in = 1'b0, rst_b_in = 1'b0, sel_n = 1'b0, i2c = 1'b0;
	logic pol = 1'b1, gang = 1'b0;
	logic [7:0] q;
	wire wr, rd, smb, reload, up, indiv;
	wire [7:0] addr, wdata, rdata;
	wire [3:0] pwr, chg;
	int error_cnt = 0, tests_run = 0;
	hcmc_top hcmc_top_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.serial_mode_select_n_in(sel_n), .power_enable_polarity_in(pol), .ganged_power_in(gang),
		.full_power_management_n_in(1'b0), .charge_enable_in(4'h5), .i2c_mode_active_in(i2c),
		.port_power_request_in(4'ha), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .smbus_mode_out(smb),
		.config_regs_reload_out(reload), .upstream_connect_allow_out(up),
		.individual_power_out(indiv), .port_power_enable_out(pwr), .port_charge_enable_out(chg));
	hcmc_host hcmc_host_inst (.core_clk_in(core_clk_in), .rdata_in(rdata), .wr_out(wr),
		.rd_out(rd), .addr_out(addr), .wdata_out(wdata));
	initial forever #50 core_clk_in = ~core_clk_in;
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Straps are sampled only at reset release, so every mode needs its own reset.
	task automatic boot(input logic s, input logic p, input logic gd);
		rst_b_in = 1'b0;
		sel_n = s;
		pol = p;
		gang = gd;
		repeat (16) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		repeat (6) @(negedge core_clk_in);
	endtask
	task automatic t_smbus();
		boot(1'b0, 1'b1, 1'b0);
		check("smbus", {7'h00, smb}, 8'h01);
		check("boot up", {7'h00, up}, 8'h00);
		hcmc_host_inst.xfer(1'b0, 8'hf8, 8'h00, q);
		check("boot stat", q, 8'h01);
		hcmc_host_inst.xfer(1'b1, 8'hf8, 8'hfc, q);
		hcmc_host_inst.xfer(1'b0, 8'hf8, 8'h00, q);
		check("zero wr", q, 8'h01);
		hcmc_host_inst.xfer(1'b1, 8'hf8, 8'h02, q);
		check("reload", {7'h00, reload}, 8'h01);
		hcmc_host_inst.xfer(1'b0, 8'hf8, 8'h00, q);
		check("mid rst", q, 8'h03);
		repeat (2) @(negedge core_clk_in);
		check("rst end", {7'h00, reload}, 8'h00);
		hcmc_host_inst.xfer(1'b0, 8'hf8, 8'h00, q);
		check("post rst", q, 8'h01);
		hcmc_host_inst.xfer(1'b1, 8'hf8, 8'h03, q);
		check("both up", {7'h00, up}, 8'h00);
		repeat (4) @(negedge core_clk_in);
		hcmc_host_inst.xfer(1'b1, 8'hf8, 8'h01, q);
		check("clr up", {7'h00, up}, 8'h01);
		hcmc_host_inst.xfer(1'b0, 8'hf0, 8'h00, q);
		check("unmapped", q, 8'h00);
	endtask
	task automatic t_i2c();
		boot(1'b1, 1'b1, 1'b0);
		check("i2c strap", {7'h00, smb}, 8'h00);
		check("indiv", {7'h00, indiv}, 8'h01);
		check("charge", {4'h0, chg}, 8'h05);
		check("pwr", {4'h0, pwr}, 8'h0a);
		i2c = 1'b1;
		repeat (6) @(negedge core_clk_in);
		check("i2c up", {7'h00, up}, 8'h00);
		hcmc_host_inst.xfer(1'b1, 8'hf8, 8'h02, q);
		check("no rst", {7'h00, reload}, 8'h00);
		i2c = 1'b0;
		repeat (6) @(negedge core_clk_in);
		check("i2c exit", {7'h00, up}, 8'h01);
	endtask
	task automatic t_ganged();
		boot(1'b1, 1'b0, 1'b1);
		check("ganged", {7'h00, indiv}, 8'h00);
		check("pwr low", {4'h0, pwr}, 8'h0f);
	endtask
	initial begin
		t_smbus();
		t_i2c();
		t_ganged();
		print_verdict();
	end
endmodule
`default_nettype wire
